// ==== sram_host.sv ====
`timescale 1ns/1ps
module sram_host #(
  parameter int PWRUP_CYCLES = sram_host_pkg::PWRUP_CYC
) (
  input logic ref_clk,
  input logic nrst,
  input logic slow_grade,
  input logic req_valid,
  input sram_host_pkg::mem_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
  output sram_host_pkg::sram_pins_s sram_out,
  input logic [sram_host_pkg::DATA_W-1:0] sram_dq_in
);
  import sram_host_pkg::*;

  host_s s_reg;
  host_s s_next;
  logic pwr_done;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic [CNT_W-1:0] tmr_cnt;
  logic tmr_done;
  logic [CNT_W-1:0] pulse_cyc;
  logic [CNT_W-1:0] wz_cyc;
  logic [CNT_W-1:0] aa_cyc;

  pwrup_wait #(
    .PWRUP_CYCLES(PWRUP_CYCLES)
  ) u_pwr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .done(pwr_done)
  );

  cycle_timer u_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(tmr_load),
    .load_val(tmr_val),
    .cnt(tmr_cnt),
    .done(tmr_done)
  );

  // The grade strap is expected to be static; changing it mid-cycle only affects later phases.
  assign pulse_cyc = slow_grade ? PULSE_S_C : PULSE_F_C;
  assign wz_cyc = slow_grade ? WZ_S_C : WZ_F_C;
  assign aa_cyc = slow_grade ? AA_S_C : AA_F_C;

  always_comb begin
    s_next = s_reg;
    s_next.rsp_valid = 1'h0;
    tmr_load = 1'h0;
    tmr_val = '0;
    case (s_reg.st)
      ST_PWRUP: begin
        s_next.pins = PINS_IDLE;
        if (pwr_done) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        s_next.pins.dq_oe = 1'h0;
        s_next.pins.we_n = 1'h1;
        if (req_valid) begin
          // Address moves only while the strobe is high.
          s_next.pins.addr = req.addr;
          s_next.pins.dq_out = req.wdata;
          s_next.sel_term = req.sel_term;
          if (req.write) begin
            s_next.pins.cs_n = 1'h1;
            s_next.st = ST_WSET;
          end else begin
            // Select stays low across reads, so the next read costs only the access time.
            s_next.pins.cs_n = 1'h0;
            tmr_load = 1'h1;
            tmr_val = aa_cyc - ONE_C;
            s_next.st = ST_READ;
          end
        end else begin
          s_next.pins.cs_n = 1'h1;
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          s_next.rdata = sram_dq_in;
          s_next.rsp_valid = 1'h1;
          s_next.st = ST_IDLE;
        end
      end
      ST_WSET: begin
        // Both fall together onto an address that settled a cycle earlier.
        s_next.pins.cs_n = 1'h0;
        s_next.pins.we_n = 1'h0;
        tmr_load = 1'h1;
        tmr_val = pulse_cyc - ONE_C;
        s_next.st = ST_WPULSE;
      end
      ST_WPULSE: begin
        // Our driver waits for the device to float first, avoiding a clash.
        if (tmr_cnt <= pulse_cyc - wz_cyc) begin
          s_next.pins.dq_oe = 1'h1;
        end
        if (tmr_done) begin
          s_next.pins.dq_oe = 1'h1;
          if (s_reg.sel_term) begin
            s_next.pins.cs_n = 1'h1;
          end else begin
            s_next.pins.we_n = 1'h1;
          end
          tmr_load = 1'h1;
          tmr_val = HOLD_C - ONE_C;
          s_next.st = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        // Data and address stay put through the hold cycle.
        if (tmr_done) begin
          s_next.pins.cs_n = 1'h1;
          s_next.pins.we_n = 1'h1;
          s_next.pins.dq_oe = 1'h0;
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next = HOST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg <= HOST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready = (s_reg.st == ST_IDLE);
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_rdata = s_reg.rdata;
  assign sram_out = s_reg.pins;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_wr_on;
    !sram_out.cs_n && !sram_out.we_n;
  endsequence

  sequence s_read_accept;
    req_valid && req_ready && !req.write;
  endsequence

  sequence s_read_wait;
    (s_reg.st == ST_READ) [*2];
  endsequence

  sequence s_write_accept;
    req_valid && req_ready && req.write;
  endsequence

  property p_pwrup_standby;
    !pwr_done |-> sram_out.cs_n && !req_ready;
  endproperty
  a_pwrup_standby: assert property (p_pwrup_standby)
    else $error("select driven during power-up wait");

  property p_read_strobe;
    (s_reg.st == ST_READ) |-> sram_out.we_n && !sram_out.cs_n && !sram_out.dq_oe;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("read cycle without strobe high and select low");

  property p_read_latency;
    s_read_accept |=> s_read_wait ##1 rsp_valid;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not after the access time");

  property p_read_capture;
    rsp_valid |-> (rsp_rdata == $past(sram_dq_in)) && $past(s_reg.st == ST_READ);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("read data not taken from the pins");

  property p_read_b2b;
    rsp_valid ##0 s_read_accept |=> !sram_out.cs_n && !$past(sram_out.cs_n);
  endproperty
  a_read_b2b: assert property (p_read_b2b)
    else $error("select released between back-to-back reads");

  property p_addr_in_write;
    s_wr_on ##1 s_wr_on |-> $stable(sram_out.addr);
  endproperty
  a_addr_in_write: assert property (p_addr_in_write)
    else $error("address moved during a write");

  property p_addr_change;
    $changed(sram_out.addr) |-> sram_out.we_n && $past(sram_out.we_n);
  endproperty
  a_addr_change: assert property (p_addr_change)
    else $error("address moved while both controls low");

  property p_write_start;
    $rose(!sram_out.cs_n && !sram_out.we_n) |->
      $past(sram_out.cs_n && sram_out.we_n) && $stable(sram_out.addr);
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write not started by both controls from high");

  property p_pulse_width;
    $rose(!sram_out.cs_n && !sram_out.we_n) |-> s_wr_on [*2];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("write pulse shorter than two cycles");

  property p_float_gap;
    $rose(!sram_out.cs_n && !sram_out.we_n) |-> !sram_out.dq_oe;
  endproperty
  a_float_gap: assert property (p_float_gap)
    else $error("data driven before device floats");

  property p_data_setup;
    $fell(!sram_out.cs_n && !sram_out.we_n) |-> $past(sram_out.dq_oe);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not set up before end of write");

  property p_data_hold;
    $fell(!sram_out.cs_n && !sram_out.we_n) |->
      sram_out.dq_oe && $stable(sram_out.dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held after end of write");

  property p_addr_setup;
    $fell(!sram_out.cs_n && !sram_out.we_n) |-> sram_out.addr == $past(sram_out.addr, 3);
  endproperty
  a_addr_setup: assert property (p_addr_setup)
    else $error("address not set up before end of write");

  property p_addr_hold;
    $fell(!sram_out.cs_n && !sram_out.we_n) |=> $stable(sram_out.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address not held after end of write");

  property p_sel_end;
    $rose(sram_out.cs_n) && !sram_out.we_n |-> sram_out.dq_oe ##1
      (sram_out.we_n && sram_out.cs_n && !sram_out.dq_oe);
  endproperty
  a_sel_end: assert property (p_sel_end)
    else $error("select-ended write did not close cleanly");

  property p_strobe_end;
    $rose(sram_out.we_n) && !sram_out.cs_n |=> sram_out.cs_n && !sram_out.dq_oe;
  endproperty
  a_strobe_end: assert property (p_strobe_end)
    else $error("strobe-ended write did not release the bus");

  property p_idle_deselect;
    (s_reg.st == ST_IDLE) && !rsp_valid |-> sram_out.cs_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("select low while idle");

  property p_rsp_single;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_single: assert property (p_rsp_single)
    else $error("read answer longer than one cycle");

  property p_write_busy;
    s_write_accept |=> !req_ready [*4] ##1 req_ready;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("write cycle length wrong");

  property p_write_addr_early;
    s_write_accept |=> sram_out.cs_n && sram_out.we_n && !sram_out.dq_oe;
  endproperty
  a_write_addr_early: assert property (p_write_addr_early)
    else $error("write address not set while controls high");

  property p_refused;
    req_valid && !req_ready |=> $stable(sram_out.addr);
  endproperty
  a_refused: assert property (p_refused)
    else $error("request taken while busy");

  property p_wdata_stable;
    s_wr_on |-> $stable(sram_out.dq_out);
  endproperty
  a_wdata_stable: assert property (p_wdata_stable)
    else $error("write data moved during the write pulse");

  property p_read_addr;
    (s_reg.st == ST_READ) ##1 (s_reg.st == ST_READ) |-> $stable(sram_out.addr);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("address moved during a read access");
endmodule : sram_host

// ==== sram_host_pkg.sv ====
// Function
// - Write strobe high selects read, low write.
// - Select-started read: address settles within 5ns.
// - Write spans later falling to first rising edge.
// - Address stable for whole write cycle.
// - Select-started write: address within 5ns.
// - Select low 45/65 ns before write end.
// - Write data valid 25/30 ns before end.
// - Write data held 5 ns after end.
// - Address valid 40/60 ns before write end.
// - Address held 5 ns after write end.
// - Address changes only with select or strobe high.
package sram_host_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int CNT_W = 3;
  localparam int T_CLK_NS = 40;
  localparam int T_PWRUP_NS = 2000000;
  localparam int PWRUP_CYC = T_PWRUP_NS / T_CLK_NS;
  localparam int T_WP_F_NS = 45;
  localparam int T_WP_S_NS = 65;
  localparam int T_CW_F_NS = 45;
  localparam int T_CW_S_NS = 65;
  localparam int T_DW_F_NS = 25;
  localparam int T_DW_S_NS = 30;
  localparam int T_AW_F_NS = 40;
  localparam int T_AW_S_NS = 60;
  localparam int T_DH_NS = 5;
  localparam int T_AH_NS = 5;
  localparam int T_WZ_F_NS = 25;
  localparam int T_WZ_S_NS = 30;
  localparam int T_AA_F_NS = 55;
  localparam int T_AA_S_NS = 70;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int PULSE_F = max2(max2(cyc_min(T_WP_F_NS), cyc_min(T_CW_F_NS)),
    max2(cyc_min(T_AW_F_NS), cyc_min(T_WZ_F_NS) + cyc_min(T_DW_F_NS)));
  localparam int PULSE_S = max2(max2(cyc_min(T_WP_S_NS), cyc_min(T_CW_S_NS)),
    max2(cyc_min(T_AW_S_NS), cyc_min(T_WZ_S_NS) + cyc_min(T_DW_S_NS)));
  localparam logic [CNT_W-1:0] PULSE_F_C = CNT_W'(PULSE_F);
  localparam logic [CNT_W-1:0] PULSE_S_C = CNT_W'(PULSE_S);
  localparam logic [CNT_W-1:0] WZ_F_C = CNT_W'(cyc_min(T_WZ_F_NS));
  localparam logic [CNT_W-1:0] WZ_S_C = CNT_W'(cyc_min(T_WZ_S_NS));
  localparam logic [CNT_W-1:0] AA_F_C = CNT_W'(cyc_min(T_AA_F_NS));
  localparam logic [CNT_W-1:0] AA_S_C = CNT_W'(cyc_min(T_AA_S_NS));
  localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(max2(cyc_min(T_DH_NS), cyc_min(T_AH_NS)));
  localparam logic [CNT_W-1:0] ONE_C = 3'h1;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WSET = 3'h3,
    ST_WPULSE = 3'h4,
    ST_WHOLD = 3'h5
  } host_state_e;

  typedef struct packed {
    logic write;
    logic sel_term;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } sram_pins_s;

  typedef struct packed {
    host_state_e st;
    logic sel_term;
    sram_pins_s pins;
    logic [DATA_W-1:0] rdata;
    logic rsp_valid;
  } host_s;

  localparam sram_pins_s PINS_IDLE = '{cs_n: 1'h1, we_n: 1'h1, addr: 12'h000,
    dq_out: 4'h0, dq_oe: 1'h0};
  localparam host_s HOST_RESET = '{st: ST_PWRUP, sel_term: 1'h0, pins: PINS_IDLE,
    rdata: 4'h0, rsp_valid: 1'h0};
endpackage : sram_host_pkg

// ==== cycle_timer.sv ====
`timescale 1ns/1ps
module cycle_timer (
  input logic ref_clk,
  input logic nrst,
  input logic load,
  input logic [sram_host_pkg::CNT_W-1:0] load_val,
  output logic [sram_host_pkg::CNT_W-1:0] cnt,
  output logic done
);
  import sram_host_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } timer_s;

  timer_s t_reg;
  timer_s t_next;

  always_comb begin
    t_next = t_reg;
    if (load) begin
      t_next.cnt = load_val;
    end else if (t_reg.cnt != '0) begin
      t_next.cnt = t_reg.cnt - ONE_C;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign cnt = t_reg.cnt;
  assign done = (t_reg.cnt == '0);
endmodule : cycle_timer

// ==== pwrup_wait.sv ====
`timescale 1ns/1ps
module pwrup_wait #(
  parameter int PWRUP_CYCLES = sram_host_pkg::PWRUP_CYC
) (
  input logic ref_clk,
  input logic nrst,
  output logic done
);
  import sram_host_pkg::*;

  localparam int CW = $clog2(PWRUP_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PWRUP_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } pwr_s;

  pwr_s p_reg;
  pwr_s p_next;

  // The counter starts at reset release, so a board reset after power-up costs one more wait.
  always_comb begin
    p_next = p_reg;
    if (!p_reg.done) begin
      if (p_reg.cnt == LAST) begin
        p_next.done = 1'h1;
      end else begin
        p_next.cnt = p_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  assign done = p_reg.done;
endmodule : pwrup_wait

// ==== sram_dev_model.sv ====
`timescale 1ns/1ps
module sram_dev_model #(
  parameter int PWRUP_NS = 300
) (
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic [sram_host_pkg::ADDR_W-1:0] addr,
  input wire logic [sram_host_pkg::DATA_W-1:0] dq,
  output logic [sram_host_pkg::DATA_W-1:0] dq_drv,
  output logic dq_en
);
  import sram_host_pkg::*;
  logic [DATA_W-1:0] mem [4096];
  logic pwr_ok;
  logic wr_on;
  initial begin
    pwr_ok = 1'b0;
    wr_on = 1'b0;
    #(PWRUP_NS) pwr_ok = 1'b1;
  end
  // Data is taken at the terminating rising edge, so a late data setup still lands.
  always @(cs_n or we_n) begin
    if (wr_on && (cs_n || we_n)) begin
      mem[addr] = dq;
    end
    wr_on = pwr_ok && !cs_n && !we_n;
  end
  assign dq_en = pwr_ok && !cs_n && we_n;
  assign dq_drv = mem[addr];
endmodule : sram_dev_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  import sram_host_pkg::*;
  localparam int PW = 8;
  logic ref_clk = 1'b0;
  logic nrst;
  logic slow_grade;
  logic req_valid;
  mem_req_s req;
  logic req_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;
  sram_pins_s sram_out;
  sram_pins_s prv;
  logic [DATA_W-1:0] sram_dq_in;
  logic [DATA_W-1:0] last_dq;
  logic [DATA_W-1:0] dev_dq;
  logic dev_en;
  int failures = 0;
  int check_count = 0;
  always #20 ref_clk = ~ref_clk;
  sram_host #(.PWRUP_CYCLES(PW)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .slow_grade(slow_grade), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sram_out(sram_out),
    .sram_dq_in(sram_dq_in));
  sram_dev_model mdl_u (.cs_n(sram_out.cs_n), .we_n(sram_out.we_n), .addr(sram_out.addr),
    .dq(sram_dq_in), .dq_drv(dev_dq), .dq_en(dev_en));
  // An undriven wire shows the inverse of its last level so stale data never passes.
  assign sram_dq_in = sram_out.dq_oe ? sram_out.dq_out : (dev_en ? dev_dq : ~last_dq);
  always @(negedge ref_clk) begin
    last_dq <= sram_dq_in;
    prv <= sram_out;
    if (nrst && !prv.cs_n && !prv.we_n) begin
      `CHK("addr_hold", prv.addr, sram_out.addr)
    end
    if (dev_en && sram_out.dq_oe) begin
      `CHK("dq_clash", sram_out.dq_out, dev_dq)
    end
  end
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic issue(input mem_req_s r);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= r;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    `CHK("ready", 1'b1, req_ready)
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask : issue
  task automatic write_op(input logic [11:0] a, input logic [3:0] d, input logic st);
    logic [14:0] tbl;
    tbl = st ? 15'h606E : 15'h605E;
    issue('{write: 1'b1, sel_term: st, addr: a, wdata: d});
    for (int k = 1; k <= 5; k++) begin
      @(negedge ref_clk);
      `CHK("ctl", tbl[15-3*k +: 3], {sram_out.cs_n, sram_out.we_n, sram_out.dq_oe})
      `CHK("waddr", a, sram_out.addr)
      if (k > 2 && k < 5) `CHK("wdata", d, sram_out.dq_out)
      if (k == 4) `CHK("dev_on", !st, dev_en)
      if (k == 2) `CHK("dev_off", 1'b0, dev_en)
    end
    `CHK("wready", 1'b1, req_ready)
    `CHK("stored", d, mdl_u.mem[a])
  endtask : write_op
  task automatic read_op(input logic [11:0] a, input logic [3:0] ex, input bit pre,
    input bit chain, input logic [11:0] na);
    if (!pre) issue('{write: 1'b0, sel_term: 1'b0, addr: a, wdata: 4'h0});
    for (int k = 1; k <= 3; k++) begin
      @(negedge ref_clk);
      `CHK("rsp", (k == 3), rsp_valid)
      `CHK("rctl", 2'h1, {sram_out.cs_n, sram_out.we_n})
      `CHK("raddr", a, sram_out.addr)
      if (k == 2 && chain) begin
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: 1'b0, sel_term: 1'b0, addr: na, wdata: 4'h0};
      end
    end
    `CHK("rdata", ex, rsp_rdata)
    if (chain) begin
      `CHK("rready", 1'b1, req_ready)
      @(posedge ref_clk);
      req_valid <= 1'b0;
    end
  endtask : read_op
  task automatic t_pwrup;
    int n;
    req_valid <= 1'b1;
    req <= '{write: 1'b1, sel_term: 1'b1, addr: 12'h123, wdata: 4'h9};
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (req_ready !== 1'b1) `CHK("pw_cs", 1'b1, sram_out.cs_n)
      if (n == PW - 1) begin
        @(posedge ref_clk);
        req_valid <= 1'b0;
      end
    end while (req_ready !== 1'b1 && n < 100);
    `CHK("pw_len", 1'b1, n >= PW + 1 && n <= PW + 2)
    $display("test pwrup done");
  endtask : t_pwrup
  task automatic t_wr_rd;
    write_op(12'h000, 4'hA, 1'b1);
    write_op(12'hFFF, 4'h5, 1'b0);
    write_op(12'h7A3, 4'hC, 1'b1);
    read_op(12'h000, 4'hA, 1'b0, 1'b0, 12'h000);
    read_op(12'hFFF, 4'h5, 1'b0, 1'b0, 12'h000);
    $display("test wr_rd done");
  endtask : t_wr_rd
  task automatic t_b2b;
    read_op(12'h000, 4'hA, 1'b0, 1'b1, 12'hFFF);
    read_op(12'hFFF, 4'h5, 1'b1, 1'b1, 12'h7A3);
    read_op(12'h7A3, 4'hC, 1'b1, 1'b0, 12'h000);
    $display("test b2b done");
  endtask : t_b2b
  task automatic t_gap;
    repeat (20) @(negedge ref_clk);
    `CHK("idle_cs", 1'b1, sram_out.cs_n)
    read_op(12'h7A3, 4'hC, 1'b0, 1'b0, 12'h000);
    write_op(12'h000, 4'h3, 1'b0);
    read_op(12'h000, 4'h3, 1'b0, 1'b0, 12'h000);
    $display("test gap done");
  endtask : t_gap
  // The slow strap must give the same cycle pattern at this clock rate.
  task automatic t_slow;
    @(posedge ref_clk);
    slow_grade <= 1'b1;
    write_op(12'h5A5, 4'h6, 1'b0);
    write_op(12'h5A6, 4'h9, 1'b1);
    read_op(12'h5A5, 4'h6, 1'b0, 1'b1, 12'h5A6);
    read_op(12'h5A6, 4'h9, 1'b1, 1'b0, 12'h000);
    $display("test slow done");
  endtask : t_slow
  initial begin
    nrst = 1'b0;
    slow_grade = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_pwrup();
    t_wr_rd();
    t_b2b();
    t_gap();
    t_slow();
    conclude();
  end
  initial begin
    #(40 * 2000);
    failures++;
    conclude();
  end
endmodule : testbench
